//--- hw/wdprc_pkg.sv
package wdprc_pkg;

    // =========================================================
    // timing
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned OSC_PER_MC = 12;
    localparam int unsigned STATES_PER_MC = 6;
    localparam logic [2:0] LAST_STATE = 3'h5;
    localparam logic [2:0] SAMPLE_STATE = 3'h4;
    localparam logic SAMPLE_PHASE = 1'b1;
    localparam int unsigned WDT_BITS = 14;
    localparam int unsigned PRE_BITS = 8;
    localparam logic [1:0] RST_FILTER_MC = 2'h2;
    localparam logic [1:0] WDT_RST_HOLD_MC = 2'h2;

    // =========================================================
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_POWER_CONTROL = 8'h87;
    localparam logic [7:0] IDX_WATCHDOG_CONTROL = 8'h8f;
    localparam logic [7:0] IDX_STATUS = 8'h90;
    localparam logic [7:0] IDX_MASK = 8'h91;
    localparam logic [7:0] IDX_SERIAL_BUFFER_REG = 8'h92;

    // =========================================================
    // reset values
    localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
    localparam logic [7:0] WATCHDOG_CONTROL_RESET = 8'h00;
    localparam logic [7:0] PORT_RESET = 8'hff;
    localparam logic [7:0] SP_RESET = 8'h07;
    localparam logic [7:0] SERIAL_BUFFER_REG_RESET = 8'h00;
    localparam int unsigned EVT_W = 3;

    // =========================================================
    // field layouts
    typedef struct packed {
        logic [2:0] rsvd;
        logic cold_start_flag;
        logic user_flag_one;
        logic user_flag_zero;
        logic halt_all_clocks_bit;
        logic cpu_nap_bit;
    } wdprc_power_control_t;

    typedef struct packed {
        logic watchdog_on_bit;
        logic watchdog_restart_bit;
        logic watchdog_run_in_sleep_bit;
        logic [1:0] rsvd;
        logic [2:0] watchdog_divider_select;
    } wdprc_watchdog_control_t;

    typedef struct packed {
        logic idle_wake;
        logic pin_reset;
        logic wdt_timeout;
    } wdprc_evt_t;

    typedef enum logic [1:0] {
        PWR_RUN = 2'b00,
        PWR_IDLE = 2'b01,
        PWR_DOWN = 2'b10
    } wdprc_pwr_t;

    typedef enum logic [2:0] {
        SEL_NONE = 3'b000,
        SEL_POWER_CONTROL = 3'b001,
        SEL_WATCHDOG_CONTROL = 3'b010,
        SEL_STATUS = 3'b011,
        SEL_MASK = 3'b100,
        SEL_SERIAL_BUFFER_REG = 3'b101
    } wdprc_sel_t;

    // prescaler terminal value (ratio minus one)
    function automatic logic [PRE_BITS-1:0] divider_limit(input logic [2:0] sel);
        case (sel)
            3'b000: divider_limit = 8'h01;
            3'b010: divider_limit = 8'h03;
            3'b001: divider_limit = 8'h07;
            3'b011: divider_limit = 8'h0f;
            3'b100: divider_limit = 8'h1f;
            3'b101: divider_limit = 8'h3f;
            3'b110: divider_limit = 8'h7f;
            default: divider_limit = 8'hff;
        endcase
    endfunction

    // time-out length in clock cycles for a given select
    function automatic longint unsigned timeout_cycles(input logic [2:0] sel);
        timeout_cycles = longint'(OSC_PER_MC) * (longint'(1) << WDT_BITS)
            * (longint'(divider_limit(sel)) + 1);
    endfunction

    function automatic longint unsigned timeout_ns(input logic [2:0] sel);
        timeout_ns = timeout_cycles(sel) * CLK_PERIOD_PS / 1000;
    endfunction

endpackage

//--- hw/wdprc_top.sv
// Behaviour
// - watchdog advances only while its enable bit is set, otherwise stands still.
// - writing the restart bit clears counter, prescaler and bit on next machine cycle.
// - in idle the watchdog runs only if run-in-sleep bit set; bit resets low.
// - divider select codes 0..7 map to ratios 2,8,4,16,32,64,128,256 in that order.
// - time-out equals 12 oscillator periods times 2^14 times prescaler ratio.
// - a time-out of the enabled watchdog raises a system reset.
// - any reset disables the watchdog and clears its count.
// - incoming clock is divided by two before internal use.
// - nap bit stops the processor clock; peripherals and interrupts stay clocked.
// - idle is left on any interrupt or any reset.
// - halt bit stops every clock including oscillator; only reset exits.
// - cold start flag set at power-up, cleared only by software write.
// - two user flags are plain storage with no hardware effect.
// - reset pin sampled at fixed phase; must be held two machine cycles.
// - short glitches on the reset pin are filtered out.
// - reset presets ports FFH, stack 07H, clears watchdog control and user flags, keeps serial buffer, cold flag, status and mask.
`timescale 1ns/100ps
module wdprc_top #(
    parameter int unsigned ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rst_pin,
    input wire logic irq_wake,
    output logic sys_reset,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic osc_en,
    output logic [7:0] port_preset,
    output logic [7:0] stack_preset,
    output logic irq
);

    initial begin
        if (ADDR_W < 10 || ADDR_W > 32) begin
            $error("wdprc_top: ADDR_W must be 10..32");
        end
    end

    // =========================================================
    // address decode
    function automatic wdprc_pkg::wdprc_sel_t decode(input logic [ADDR_W-1:0] a);
        logic [7:0] idx;
        idx = a[9:2];
        if (a[1:0] != 2'b00 || (ADDR_W > 10 && |(a >> 10))) begin
            decode = wdprc_pkg::SEL_NONE;
        end else if (idx == wdprc_pkg::IDX_POWER_CONTROL) begin
            decode = wdprc_pkg::SEL_POWER_CONTROL;
        end else if (idx == wdprc_pkg::IDX_WATCHDOG_CONTROL) begin
            decode = wdprc_pkg::SEL_WATCHDOG_CONTROL;
        end else if (idx == wdprc_pkg::IDX_STATUS) begin
            decode = wdprc_pkg::SEL_STATUS;
        end else if (idx == wdprc_pkg::IDX_MASK) begin
            decode = wdprc_pkg::SEL_MASK;
        end else if (idx == wdprc_pkg::IDX_SERIAL_BUFFER_REG) begin
            decode = wdprc_pkg::SEL_SERIAL_BUFFER_REG;
        end else begin
            decode = wdprc_pkg::SEL_NONE;
        end
    endfunction

    // =========================================================
    // declarations
    logic pin_meta;
    logic pin_sync;
    logic phase;
    logic [2:0] state_idx;
    logic mc_tick;
    logic sample_strobe;
    logic [1:0] high_samples;
    logic ext_active;
    logic ext_active_d;
    logic [1:0] wdt_hold;
    logic next_sys_reset;
    wdprc_pkg::wdprc_pwr_t pwr;
    wdprc_pkg::wdprc_pwr_t next_pwr;
    wdprc_pkg::wdprc_power_control_t power_control;
    wdprc_pkg::wdprc_power_control_t power_control_wr;
    wdprc_pkg::wdprc_watchdog_control_t watchdog_control;
    wdprc_pkg::wdprc_watchdog_control_t watchdog_control_wr;
    wdprc_pkg::wdprc_evt_t status;
    wdprc_pkg::wdprc_evt_t mask;
    wdprc_pkg::wdprc_evt_t evt;
    logic cold_flag;
    logic user_one;
    logic user_zero;
    logic [7:0] serial_buffer_reg;
    logic [7:0] rd_byte;
    logic access;
    logic wr_fire;
    wdprc_pkg::wdprc_sel_t sel;
    logic wdt_run;
    logic wdt_timeout;
    logic [wdprc_pkg::WDT_BITS-1:0] wdt_count;
    logic wake;

    assign access = psel && penable;
    assign sel = decode(paddr);
    assign wr_fire = access && pready && pwrite;
    assign power_control_wr = wdprc_pkg::wdprc_power_control_t'(pwdata[7:0]);
    assign watchdog_control_wr = wdprc_pkg::wdprc_watchdog_control_t'(pwdata[7:0]);

    // =========================================================
    // reset pin synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end else begin
            pin_meta <= rst_pin;
            pin_sync <= pin_meta;
        end
    end

    // =========================================================
    // clock divide by two and machine cycle states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= 1'b0;
            state_idx <= 3'h0;
        end else begin
            phase <= ~phase;
            if (phase) begin
                if (state_idx == wdprc_pkg::LAST_STATE) begin
                    state_idx <= 3'h0;
                end else begin
                    state_idx <= state_idx + 3'h1;
                end
            end
        end
    end

    // the sequencer keeps running in power-down so the pin can still be seen
    assign mc_tick = phase && (state_idx == wdprc_pkg::LAST_STATE);
    assign sample_strobe = (phase == wdprc_pkg::SAMPLE_PHASE)
        && (state_idx == wdprc_pkg::SAMPLE_STATE);

    // =========================================================
    // reset pin filter: consecutive high samples, one per machine cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_samples <= 2'h0;
            ext_active_d <= 1'b0;
        end else begin
            ext_active_d <= ext_active;
            if (sample_strobe) begin
                if (!pin_sync) begin
                    high_samples <= 2'h0;
                end else if (high_samples != wdprc_pkg::RST_FILTER_MC) begin
                    high_samples <= high_samples + 2'h1;
                end
            end
        end
    end

    // a pulse that meets fewer than two samples in a row never reaches the count
    assign ext_active = (high_samples == wdprc_pkg::RST_FILTER_MC);

    // =========================================================
    // system reset generation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_hold <= 2'h0;
        end else if (wdt_timeout) begin
            wdt_hold <= wdprc_pkg::WDT_RST_HOLD_MC;
        end else if (mc_tick && wdt_hold != 2'h0) begin
            wdt_hold <= wdt_hold - 2'h1;
        end
    end

    assign next_sys_reset = ext_active || wdt_timeout || (wdt_hold != 2'h0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_reset <= 1'b1;
        end else begin
            sys_reset <= next_sys_reset;
        end
    end

    // =========================================================
    // power state
    assign wake = (pwr == wdprc_pkg::PWR_IDLE) && irq_wake;

    always_comb begin
        next_pwr = pwr;
        case (pwr)
            wdprc_pkg::PWR_RUN: begin
                if (wr_fire && sel == wdprc_pkg::SEL_POWER_CONTROL) begin
                    if (power_control_wr.halt_all_clocks_bit) begin
                        next_pwr = wdprc_pkg::PWR_DOWN;
                    end else if (power_control_wr.cpu_nap_bit) begin
                        next_pwr = wdprc_pkg::PWR_IDLE;
                    end
                end
            end
            wdprc_pkg::PWR_IDLE: begin
                if (irq_wake) begin
                    next_pwr = wdprc_pkg::PWR_RUN;
                end
            end
            wdprc_pkg::PWR_DOWN: begin
                next_pwr = wdprc_pkg::PWR_DOWN;
            end
            default: begin
                next_pwr = wdprc_pkg::PWR_RUN;
            end
        endcase
        if (next_sys_reset) begin
            next_pwr = wdprc_pkg::PWR_RUN;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr <= wdprc_pkg::PWR_RUN;
            cpu_clk_en <= 1'b0;
            periph_clk_en <= 1'b1;
            osc_en <= 1'b1;
        end else begin
            pwr <= next_pwr;
            cpu_clk_en <= (next_pwr == wdprc_pkg::PWR_RUN) && !next_sys_reset;
            periph_clk_en <= (next_pwr != wdprc_pkg::PWR_DOWN);
            osc_en <= (next_pwr != wdprc_pkg::PWR_DOWN);
        end
    end

    // =========================================================
    // power control flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cold_flag <= 1'b1;
        end else if (wr_fire && sel == wdprc_pkg::SEL_POWER_CONTROL) begin
            cold_flag <= power_control_wr.cold_start_flag;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            user_one <= wdprc_pkg::POWER_CONTROL_RESET[3];
            user_zero <= wdprc_pkg::POWER_CONTROL_RESET[2];
        end else if (sys_reset) begin
            user_one <= wdprc_pkg::POWER_CONTROL_RESET[3];
            user_zero <= wdprc_pkg::POWER_CONTROL_RESET[2];
        end else if (wr_fire && sel == wdprc_pkg::SEL_POWER_CONTROL) begin
            user_one <= power_control_wr.user_flag_one;
            user_zero <= power_control_wr.user_flag_zero;
        end
    end

    // one driver for the whole packed register image
    assign power_control = wdprc_pkg::wdprc_power_control_t'({3'h0, cold_flag, user_one, user_zero,
        pwr == wdprc_pkg::PWR_DOWN, pwr == wdprc_pkg::PWR_IDLE});

    // =========================================================
    // watchdog control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_control <= wdprc_pkg::wdprc_watchdog_control_t'(wdprc_pkg::WATCHDOG_CONTROL_RESET);
        end else if (sys_reset) begin
            watchdog_control <= wdprc_pkg::wdprc_watchdog_control_t'(wdprc_pkg::WATCHDOG_CONTROL_RESET);
        end else if (wr_fire && sel == wdprc_pkg::SEL_WATCHDOG_CONTROL) begin
            watchdog_control.watchdog_on_bit <= watchdog_control_wr.watchdog_on_bit;
            watchdog_control.watchdog_run_in_sleep_bit <= watchdog_control_wr.watchdog_run_in_sleep_bit;
            watchdog_control.watchdog_divider_select <= watchdog_control_wr.watchdog_divider_select;
            // a new restart request wins over the self-clear
            if (watchdog_control_wr.watchdog_restart_bit) begin
                watchdog_control.watchdog_restart_bit <= 1'b1;
            end else if (mc_tick) begin
                watchdog_control.watchdog_restart_bit <= 1'b0;
            end
        end else if (mc_tick) begin
            watchdog_control.watchdog_restart_bit <= 1'b0;
        end
    end

    // halted in power-down because every clock stands there
    assign wdt_run = watchdog_control.watchdog_on_bit
        && (pwr != wdprc_pkg::PWR_DOWN)
        && ((pwr != wdprc_pkg::PWR_IDLE) || watchdog_control.watchdog_run_in_sleep_bit);

    wdprc_wdt_core #(
        .WDT_W(wdprc_pkg::WDT_BITS),
        .PRE_W(wdprc_pkg::PRE_BITS)
    ) u_core (
        .clk(pclk),
        .rstn(presetn),
        .clear(sys_reset),
        .tick(mc_tick),
        .run(wdt_run),
        .restart(watchdog_control.watchdog_restart_bit),
        .sel(watchdog_control.watchdog_divider_select),
        .timeout(wdt_timeout),
        .count(wdt_count)
    );

    // =========================================================
    // reset presets and serial buffer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_preset <= wdprc_pkg::PORT_RESET;
            stack_preset <= wdprc_pkg::SP_RESET;
        end else if (sys_reset) begin
            port_preset <= wdprc_pkg::PORT_RESET;
            stack_preset <= wdprc_pkg::SP_RESET;
        end
    end

    // only power-up clears it; system resets leave it alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_buffer_reg <= wdprc_pkg::SERIAL_BUFFER_REG_RESET;
        end else if (wr_fire && sel == wdprc_pkg::SEL_SERIAL_BUFFER_REG) begin
            serial_buffer_reg <= pwdata[7:0];
        end
    end

    // =========================================================
    // event status, mask and interrupt
    assign evt.wdt_timeout = wdt_timeout;
    assign evt.pin_reset = ext_active && !ext_active_d;
    assign evt.idle_wake = wake;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= '0;
        end else if (wr_fire && sel == wdprc_pkg::SEL_STATUS) begin
            status <= (status & ~wdprc_pkg::wdprc_evt_t'(pwdata[wdprc_pkg::EVT_W-1:0])) | evt;
        end else begin
            status <= status | evt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask <= '0;
        end else if (wr_fire && sel == wdprc_pkg::SEL_MASK) begin
            mask <= wdprc_pkg::wdprc_evt_t'(pwdata[wdprc_pkg::EVT_W-1:0]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask);
        end
    end

    // =========================================================
    // apb slave: one wait state, read data registered with pready
    always_comb begin
        rd_byte = 8'h00;
        case (sel)
            wdprc_pkg::SEL_POWER_CONTROL: rd_byte = power_control;
            wdprc_pkg::SEL_WATCHDOG_CONTROL: rd_byte = watchdog_control;
            wdprc_pkg::SEL_STATUS: rd_byte = {5'h00, status};
            wdprc_pkg::SEL_MASK: rd_byte = {5'h00, mask};
            wdprc_pkg::SEL_SERIAL_BUFFER_REG: rd_byte = serial_buffer_reg;
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= access && !pready;
            pslverr <= access && !pready && (sel == wdprc_pkg::SEL_NONE);
            if (access && !pready && !pwrite) begin
                prdata <= {24'h00_0000, rd_byte};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

endmodule

//--- hw/wdprc_wdt_core.sv
`timescale 1ns/100ps
module wdprc_wdt_core #(
    parameter int unsigned WDT_W = wdprc_pkg::WDT_BITS,
    parameter int unsigned PRE_W = wdprc_pkg::PRE_BITS
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic clear,
    input wire logic tick,
    input wire logic run,
    input wire logic restart,
    input wire logic [2:0] sel,
    output logic timeout,
    output logic [WDT_W-1:0] count
);

    initial begin
        if (WDT_W < 2 || PRE_W != wdprc_pkg::PRE_BITS) begin
            $error("wdprc_wdt_core: unsupported widths");
        end
    end

    logic [PRE_W-1:0] prescale;
    logic [PRE_W-1:0] limit;

    assign limit = wdprc_pkg::divider_limit(sel);

    // =========================================================
    // prescaler and 14-bit counter, one step per machine cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prescale <= '0;
            count <= '0;
            timeout <= 1'b0;
        end else begin
            timeout <= 1'b0;
            if (clear) begin
                prescale <= '0;
                count <= '0;
            end else if (tick) begin
                if (restart) begin
                    prescale <= '0;
                    count <= '0;
                end else if (run) begin
                    if (prescale == limit) begin
                        prescale <= '0;
                        count <= count + 1'b1;
                        timeout <= &count;
                    end else begin
                        prescale <= prescale + 1'b1;
                    end
                end
            end
        end
    end

endmodule

//--- testbench/wdprc_top_monitor.sv
`timescale 1ns/100ps
module wdprc_top_monitor #(
    parameter int unsigned ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rst_pin,
    input wire logic irq_wake,
    input wire logic sys_reset,
    input wire logic cpu_clk_en,
    input wire logic periph_clk_en,
    input wire logic osc_en,
    input wire logic [7:0] port_preset,
    input wire logic [7:0] stack_preset
);
    // =========================================================
    // properties
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_one_wait: assert property ($rose(penable) && psel |=> pready)
        else $error("pready not one cycle after access start");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata nonzero outside answer");
    a_misalign_err: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access not refused");
    a_down_clocks: assert property (!osc_en |-> !periph_clk_en && !cpu_clk_en)
        else $error("clock running in power-down");
    a_periph_clock: assert property (periph_clk_en == osc_en)
        else $error("peripheral clock stopped outside power-down");
    a_reset_cpu: assert property (sys_reset [*2] |-> !cpu_clk_en)
        else $error("processor clock runs in reset");
    a_preset_values: assert property (port_preset == 8'hff && stack_preset == 8'h07)
        else $error("port or stack preset wrong");
    a_pin_resets: assert property (rst_pin [*8] ##1 rst_pin [*8] ##1 rst_pin [*8]
        |-> ##[0:16] sys_reset) else $error("held reset pin gave no reset");
    a_reset_long: assert property ($rose(sys_reset) |=> sys_reset [*8])
        else $error("system reset too short");
    a_wake_exit: assert property (!cpu_clk_en && osc_en && irq_wake && !sys_reset
        |-> ##[1:3] cpu_clk_en) else $error("interrupt did not end idle");
endmodule

bind wdprc_top wdprc_top_monitor #(.ADDR_W(ADDR_W)) u_mon (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rst_pin(rst_pin), .irq_wake(irq_wake), .sys_reset(sys_reset),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .osc_en(osc_en),
    .port_preset(port_preset), .stack_preset(stack_preset));

//--- testbench/wdprc_top_tb_top.sv
`timescale 1ns/100ps
module wdprc_top_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic rst_pin = 1'b0;
    logic irq_wake = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, sys_reset, cpu_clk_en, periph_clk_en, osc_en, irq;
    logic [7:0] port_preset, stack_preset;
    logic [32:0] expq[$];
    logic [32:0] e;
    logic [7:0] fl, sb;
    int n_errors = 0;
    int compares = 0;
    int cyc = 0;

    always #2.5 pclk = ~pclk;

    wdprc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rst_pin(rst_pin), .irq_wake(irq_wake), .sys_reset(sys_reset),
        .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .osc_en(osc_en),
        .port_preset(port_preset), .stack_preset(stack_preset), .irq(irq));

    // =========================================================
    // checking
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // the watcher takes the oldest note at each answered access
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && expq.size() > 0) begin
            e = expq.pop_front();
            check("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
            if (!pwrite)
                check("prdata", prdata, e[31:0]);
        end
    end

    // a hang ends the run as a failure
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            give_verdict();
        end
    end

    // =========================================================
    // apb master
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                       input logic [32:0] ex);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, d};
        expq.push_back(ex);
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] v);
        apb(1'b0, idx, 8'h00, {9'h0, 16'h0, v});
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d, 33'h0);
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // =========================================================
    // scenarios
    initial begin
        fl = 8'($urandom(86976));
        wait_clk(16);
        presetn <= 1'b1;
        wait_clk(2);
        rd(wdprc_pkg::IDX_POWER_CONTROL, 8'h10);
        rd(wdprc_pkg::IDX_WATCHDOG_CONTROL, 8'h00);
        apb(1'b0, 8'h00, 8'h00, {1'b1, 32'h0});
        fl = 8'h10 | (fl & 8'h0c);
        sb = 8'($urandom());
        wr(wdprc_pkg::IDX_POWER_CONTROL, fl);
        rd(wdprc_pkg::IDX_POWER_CONTROL, fl);
        wr(wdprc_pkg::IDX_SERIAL_BUFFER_REG, sb);
        wr(wdprc_pkg::IDX_POWER_CONTROL, 8'h00);
        rd(wdprc_pkg::IDX_POWER_CONTROL, 8'h00);
        // restart bit must drop within one machine cycle, rest stays
        wr(wdprc_pkg::IDX_WATCHDOG_CONTROL, 8'hc5);
        wait_clk(30);
        rd(wdprc_pkg::IDX_WATCHDOG_CONTROL, 8'h85);
        wr(wdprc_pkg::IDX_POWER_CONTROL, 8'h01);
        wait_clk(3);
        check("idle cpu clock", {31'h0, cpu_clk_en}, 32'h0);
        check("idle periph clock", {31'h0, periph_clk_en}, 32'h1);
        irq_wake <= 1'b1;
        wait_clk(1);
        irq_wake <= 1'b0;
        wait_clk(3);
        check("woken cpu clock", {31'h0, cpu_clk_en}, 32'h1);
        rd(wdprc_pkg::IDX_STATUS, 8'h04);
        wr(wdprc_pkg::IDX_STATUS, 8'h04);
        rd(wdprc_pkg::IDX_STATUS, 8'h00);
        wr(wdprc_pkg::IDX_MASK, 8'h02);
        // a pulse shorter than a machine cycle meets at most one sample
        rst_pin <= 1'b1;
        wait_clk(6);
        rst_pin <= 1'b0;
        repeat (30) begin
            @(posedge pclk);
            check("glitch reset", {31'h0, sys_reset}, 32'h0);
        end
        wr(wdprc_pkg::IDX_POWER_CONTROL, 8'h0e);
        wait_clk(3);
        check("down osc", {31'h0, osc_en}, 32'h0);
        irq_wake <= 1'b1;
        wait_clk(4);
        irq_wake <= 1'b0;
        check("down after irq", {31'h0, osc_en}, 32'h0);
        rst_pin <= 1'b1;
        wait_clk(36);
        check("pin reset", {31'h0, sys_reset}, 32'h1);
        rst_pin <= 1'b0;
        while (sys_reset !== 1'b0) @(posedge pclk);
        wait_clk(2);
        check("osc after reset", {31'h0, osc_en}, 32'h1);
        check("irq raised", {31'h0, irq}, 32'h1);
        rd(wdprc_pkg::IDX_POWER_CONTROL, 8'h00);
        rd(wdprc_pkg::IDX_WATCHDOG_CONTROL, 8'h00);
        rd(wdprc_pkg::IDX_SERIAL_BUFFER_REG, sb);
        rd(wdprc_pkg::IDX_STATUS, 8'h02);
        wr(wdprc_pkg::IDX_MASK, 8'h00);
        wait_clk(3);
        check("irq masked", {31'h0, irq}, 32'h0);
        wr(wdprc_pkg::IDX_MASK, 8'h02);
        wr(wdprc_pkg::IDX_STATUS, 8'h02);
        wait_clk(3);
        check("irq cleared", {31'h0, irq}, 32'h0);
        give_verdict();
    end
endmodule
